/* hw/uema_pkg.sv */
package uema_pkg;

    // register byte offsets
    localparam logic [7:0] UEMA_OFF_ERR_IRQ_EN   = 8'h00;
    localparam logic [7:0] UEMA_OFF_DEV_ADDR     = 8'h04;
    localparam logic [7:0] UEMA_OFF_FRAME_LOW    = 8'h08;
    localparam logic [7:0] UEMA_OFF_FRAME_HIGH   = 8'h0c;
    localparam logic [7:0] UEMA_OFF_ERR_STATUS   = 8'h10;
    localparam logic [7:0] UEMA_OFF_ERR_CLEAR    = 8'h14;
    localparam logic [7:0] UEMA_OFF_USB_IRQ_EN   = 8'h18;

    // error bit positions
    localparam int UEMA_BIT_PID       = 0;
    localparam int UEMA_BIT_CRC5_EOF  = 1;
    localparam int UEMA_BIT_CRC16     = 2;
    localparam int UEMA_BIT_FIELD     = 3;
    localparam int UEMA_BIT_TURN      = 4;
    localparam int UEMA_BIT_DMA       = 5;
    localparam int UEMA_BIT_BUSMATRIX = 6;
    localparam int UEMA_BIT_BITSTUFF  = 7;

    // address register fields
    localparam int UEMA_BIT_LOW_SPEED = 7;

    // master error irq enable position in the usb irq enable register
    localparam int UEMA_BIT_ERR_MASTER = 1;

    // reset values
    localparam logic [7:0]  UEMA_RST_ERR_EN   = 8'h00;
    localparam logic [7:0]  UEMA_RST_ADDR     = 8'h00;
    localparam logic [10:0] UEMA_RST_FRAME    = 11'h000;
    localparam logic [7:0]  UEMA_RST_STATUS   = 8'h00;
    localparam logic [7:0]  UEMA_RST_USB_IE   = 8'h00;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } uema_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } uema_apb_rsp_t;

    typedef struct packed {
        logic        sof_valid;
        logic [10:0] frame_number;
    } uema_sof_t;

endpackage

/* hw/uema_top.sv */
`timescale 1ns/100ps
// Functional notes
// - bit 7 enables bit stuff error interrupt
// - bit 6 enables bus matrix error interrupt
// - bit 5 enables DMA error interrupt
// - bit 4 enables turnaround timeout interrupt
// - bit 3 enables field size error interrupt
// - bit 2 enables data CRC failure interrupt
// - bit 1 token CRC (device) or EOF (host)
// - bit 0 enables PID check failure interrupt
// - errors reach usb flag only with master enable
// - bits 31 to 8 read zero
// - address bit 7 selects low speed token
// - address bits 6:0 hold device address
// - frame low register shows frame bits 7:0
// - frame number captured on every SOF token
// - frame high register shows frame bits 10:8
module uema_top (
    // clock and reset
    input  wire logic                    clock,
    input  wire logic                    rst,
    // apb slave
    input  wire uema_pkg::uema_apb_req_t apb_req,
    output uema_pkg::uema_apb_rsp_t      apb_rsp,
    // error events from the usb engine, one-cycle pulses
    input  wire logic [7:0]              err_event,
    input  wire logic                    host_mode,
    // received start-of-frame token
    input  wire uema_pkg::uema_sof_t     sof_in,
    // settings toward the usb engine
    output logic [6:0]                   device_address,
    output logic                         low_speed_token_sel,
    // interrupts
    output logic                         usb_error_irq,
    output logic                         usb_irq_flag
);
    import uema_pkg::*;

    // bus strobes and address decode
    logic        wr_en;
    logic        rd_en;
    logic        wr_err_en;
    logic        wr_addr;
    logic        wr_clear;
    logic        wr_usb_ie;
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] rd_word;

    // register state and next values
    logic [7:0]  err_en_q;
    logic [7:0]  err_en_d;
    logic [7:0]  addr_q;
    logic [7:0]  addr_d;
    logic [10:0] frame_q;
    logic [10:0] frame_d;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  usb_ie_q;
    logic [7:0]  usb_ie_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        slverr_q;
    logic        slverr_d;

    // named views of the flags and their enables
    logic        bitstuff_err_flag;
    logic        bus_matrix_err_flag;
    logic        dma_err_flag;
    logic        turnaround_timeout_flag;
    logic        field_size_err_flag;
    logic        data_crc_fail_flag;
    logic        token_crc_err_flag;
    logic        pid_check_fail_flag;
    logic        bitstuff_err_irq_en;
    logic        bus_matrix_err_irq_en;
    logic        dma_err_irq_en;
    logic        turnaround_timeout_irq_en;
    logic        field_size_err_irq_en;
    logic        data_crc_fail_irq_en;
    logic        token_crc_err_irq_en;
    logic        frame_end_err_irq_en;
    logic        pid_check_fail_irq_en;
    logic        usb_error_irq_master_en;
    logic [7:0]  ev_mapped;
    logic [7:0]  err_masked;

    // a write lands at the access edge
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    // read data is taken in setup so it is registered by the access edge
    assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    always_comb begin
        wr_err_en = wr_en && (apb_req.paddr == UEMA_OFF_ERR_IRQ_EN);
        wr_addr   = wr_en && (apb_req.paddr == UEMA_OFF_DEV_ADDR);
        wr_clear  = wr_en && (apb_req.paddr == UEMA_OFF_ERR_CLEAR);
        wr_usb_ie = wr_en && (apb_req.paddr == UEMA_OFF_USB_IRQ_EN);
        wr_hit    = wr_err_en || wr_addr || wr_clear || wr_usb_ie;
    end

    // bit 1 carries the token crc error in device mode and the frame end
    // error in host mode; the engine puts the right one on that line
    always_comb begin
        ev_mapped = err_event;
        ev_mapped[UEMA_BIT_CRC5_EOF] = err_event[UEMA_BIT_CRC5_EOF];
    end

    always_comb begin
        bitstuff_err_flag         = status_q[UEMA_BIT_BITSTUFF];
        bus_matrix_err_flag       = status_q[UEMA_BIT_BUSMATRIX];
        dma_err_flag              = status_q[UEMA_BIT_DMA];
        turnaround_timeout_flag   = status_q[UEMA_BIT_TURN];
        field_size_err_flag       = status_q[UEMA_BIT_FIELD];
        data_crc_fail_flag        = status_q[UEMA_BIT_CRC16];
        token_crc_err_flag        = status_q[UEMA_BIT_CRC5_EOF];
        pid_check_fail_flag       = status_q[UEMA_BIT_PID];
        bitstuff_err_irq_en       = err_en_q[UEMA_BIT_BITSTUFF];
        bus_matrix_err_irq_en     = err_en_q[UEMA_BIT_BUSMATRIX];
        dma_err_irq_en            = err_en_q[UEMA_BIT_DMA];
        turnaround_timeout_irq_en = err_en_q[UEMA_BIT_TURN];
        field_size_err_irq_en     = err_en_q[UEMA_BIT_FIELD];
        data_crc_fail_irq_en      = err_en_q[UEMA_BIT_CRC16];
        token_crc_err_irq_en      = err_en_q[UEMA_BIT_CRC5_EOF] && !host_mode;
        frame_end_err_irq_en      = err_en_q[UEMA_BIT_CRC5_EOF] && host_mode;
        pid_check_fail_irq_en     = err_en_q[UEMA_BIT_PID];
        usb_error_irq_master_en   = usb_ie_q[UEMA_BIT_ERR_MASTER];
    end

    // error interrupt enable register
    always_comb begin
        err_en_d = err_en_q;
        if (wr_err_en) begin
            err_en_d = apb_req.pwdata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            err_en_q <= UEMA_RST_ERR_EN;
        end else begin
            err_en_q <= err_en_d;
        end
    end

    // address register: speed select on top, device address below
    always_comb begin
        addr_d = addr_q;
        if (wr_addr) begin
            addr_d = apb_req.pwdata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_q <= UEMA_RST_ADDR;
        end else begin
            addr_q <= addr_d;
        end
    end

    // frame number, taken whole on each start-of-frame token
    always_comb begin
        frame_d = frame_q;
        if (sof_in.sof_valid) begin
            frame_d = sof_in.frame_number;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frame_q <= UEMA_RST_FRAME;
        end else begin
            frame_q <= frame_d;
        end
    end

    // one sticky flag per source; an event wins over a clear in one cycle
    for (genvar gi = 0; gi < 8; gi++) begin : g_flag
        always_comb begin
            status_d[gi] = status_q[gi];
            if (wr_clear && apb_req.pwdata[gi]) begin
                status_d[gi] = 1'b0;
            end
            if (ev_mapped[gi]) begin
                status_d[gi] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_q <= UEMA_RST_STATUS;
        end else begin
            status_q <= status_d;
        end
    end

    // usb interrupt enable register, bit 1 passes error interrupts on
    always_comb begin
        usb_ie_d = usb_ie_q;
        if (wr_usb_ie) begin
            usb_ie_d = apb_req.pwdata[7:0];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            usb_ie_q <= UEMA_RST_USB_IE;
        end else begin
            usb_ie_q <= usb_ie_d;
        end
    end

    // read mux; unimplemented upper bits stay zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (apb_req.paddr)
            UEMA_OFF_ERR_IRQ_EN: rd_word[7:0] = err_en_q;
            UEMA_OFF_DEV_ADDR:   rd_word[7:0] = addr_q;
            UEMA_OFF_FRAME_LOW:  rd_word[7:0] = frame_q[7:0];
            UEMA_OFF_FRAME_HIGH: rd_word[2:0] = frame_q[10:8];
            UEMA_OFF_ERR_STATUS: rd_word[7:0] = status_q;
            UEMA_OFF_ERR_CLEAR:  rd_word = 32'h0000_0000;
            UEMA_OFF_USB_IRQ_EN: rd_word[7:0] = usb_ie_q;
            default:             rd_hit = 1'b0;
        endcase
    end

    // read data and its error are captured in setup; the data stands until the next read, the error for one cycle
    always_comb begin
        rdata_d  = rdata_q;
        slverr_d = 1'b0;
        if (rd_en) begin
            rdata_d  = rd_word;
            slverr_d = !rd_hit;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q  <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // each enable bit gates its own latched flag; bit 1 follows the mode
    always_comb begin
        err_masked = status_q & err_en_q;
        err_masked[UEMA_BIT_CRC5_EOF] = token_crc_err_flag &&
            (token_crc_err_irq_en || frame_end_err_irq_en);
        usb_error_irq = |err_masked;
    end
    assign usb_irq_flag = usb_error_irq && usb_error_irq_master_en;

    assign device_address      = addr_q[6:0];
    assign low_speed_token_sel = addr_q[UEMA_BIT_LOW_SPEED];

    // zero wait states; a write error is flagged in the access cycle
    always_comb begin
        apb_rsp.pready  = 1'b1;
        apb_rsp.prdata  = rdata_q;
        apb_rsp.pslverr = slverr_q;
        if (apb_req.pwrite) begin
            apb_rsp.pslverr = apb_req.psel && apb_req.penable && !wr_hit;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    bitstuff_gate_a: assert property ((status_q[7] && err_en_q[7]) |-> usb_error_irq)
        else $error("bit stuff error not raised");
    busmatrix_gate_a: assert property ((status_q[6] && err_en_q[6]) |-> usb_error_irq)
        else $error("bus matrix error not raised");
    dma_gate_a: assert property ((status_q[5] && err_en_q[5]) |-> usb_error_irq)
        else $error("dma error not raised");
    turn_gate_a: assert property ((status_q[4] && err_en_q[4]) |-> usb_error_irq)
        else $error("turnaround error not raised");
    field_gate_a: assert property ((status_q[3] && err_en_q[3]) |-> usb_error_irq)
        else $error("field size error not raised");
    crc16_gate_a: assert property ((status_q[2] && err_en_q[2]) |-> usb_error_irq)
        else $error("data crc error not raised");
    bit1_gate_a: assert property ((status_q[1] && err_en_q[1]) |-> usb_error_irq)
        else $error("bit 1 error not raised");
    pid_gate_a: assert property ((status_q[0] && err_en_q[0]) |-> usb_error_irq)
        else $error("pid error not raised");

    // a lone flag with its enable clear must stay silent
    bitstuff_mask_a: assert property (
        (status_q == 8'h80 && !err_en_q[7]) |-> !usb_error_irq)
        else $error("bit stuff error not masked");
    busmatrix_mask_a: assert property (
        (status_q == 8'h40 && !err_en_q[6]) |-> !usb_error_irq)
        else $error("bus matrix error not masked");
    dma_mask_a: assert property (
        (status_q == 8'h20 && !err_en_q[5]) |-> !usb_error_irq)
        else $error("dma error not masked");
    turn_mask_a: assert property (
        (status_q == 8'h10 && !err_en_q[4]) |-> !usb_error_irq)
        else $error("turnaround error not masked");
    field_mask_a: assert property (
        (status_q == 8'h08 && !err_en_q[3]) |-> !usb_error_irq)
        else $error("field size error not masked");
    crc16_mask_a: assert property (
        (status_q == 8'h04 && !err_en_q[2]) |-> !usb_error_irq)
        else $error("data crc error not masked");
    bit1_mask_a: assert property (
        (status_q == 8'h02 && !err_en_q[1]) |-> !usb_error_irq)
        else $error("bit 1 error not masked");
    pid_mask_a: assert property (
        (status_q == 8'h01 && !err_en_q[0]) |-> !usb_error_irq)
        else $error("pid error not masked");
    mask_all_a: assert property ((err_en_q == 8'h00) |-> !usb_error_irq)
        else $error("masked error raised irq");

    master_gate_a: assert property (!usb_ie_q[UEMA_BIT_ERR_MASTER] |-> !usb_irq_flag)
        else $error("flag set without master enable");
    master_pass_a: assert property (
        (usb_error_irq && usb_ie_q[UEMA_BIT_ERR_MASTER]) |-> usb_irq_flag)
        else $error("enabled error did not reach flag");
    upper_zero_a: assert property (rdata_q[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    addr_write_a: assert property ((wr_addr) |=>
        {low_speed_token_sel, device_address} == $past(apb_req.pwdata[7:0]))
        else $error("address write lost");
    addr_read_a: assert property (
        (rd_en && apb_req.paddr == UEMA_OFF_DEV_ADDR) |=> rdata_q == {24'h000000, $past(addr_q)})
        else $error("address read wrong");
    frame_low_a: assert property (
        (rd_en && apb_req.paddr == UEMA_OFF_FRAME_LOW) |=>
        rdata_q == {24'h000000, $past(frame_q[7:0])})
        else $error("frame low read wrong");
    sof_capture_a: assert property (sof_in.sof_valid |=> frame_q == $past(sof_in.frame_number))
        else $error("frame number not captured");
    reset_zero_a: assert property (@(posedge clock) disable iff (1'b0)
        rst |-> (err_en_q == 8'h00 && addr_q == 8'h00 && frame_q == 11'h000))
        else $error("register not zero in reset");
    frame_high_a: assert property (
        (rd_en && apb_req.paddr == UEMA_OFF_FRAME_HIGH) |=>
        rdata_q == {29'h00000000, $past(frame_q[10:8])})
        else $error("frame high read wrong");

    // flags only move through events and clears
    flag_sticky_a: assert property ((status_q[0] && !wr_en) |=> status_q[0])
        else $error("flag lost without clear");
    set_wins_a: assert property (
        (wr_clear && apb_req.pwdata[UEMA_BIT_PID] && ev_mapped[UEMA_BIT_PID]) |=>
        pid_check_fail_flag)
        else $error("event lost to clear");
    clear_works_a: assert property (
        (wr_clear && apb_req.pwdata[UEMA_BIT_PID] && !ev_mapped[UEMA_BIT_PID]) |=>
        !pid_check_fail_flag)
        else $error("flag not cleared");
    enable_keeps_a: assert property (
        (wr_err_en && ev_mapped == 8'h00 && !wr_clear) |=> status_q == $past(status_q))
        else $error("enable write changed flags");

    // main scenarios
    sof_seen_c: cover property (sof_in.sof_valid ##1 sof_in.sof_valid);
    irq_seen_c: cover property (usb_irq_flag);
    clear_seen_c: cover property (wr_clear ##1 !usb_error_irq);
    host_bit1_c: cover property (host_mode && frame_end_err_irq_en && token_crc_err_flag);
endmodule

/* verif/uema_usb_engine_model.sv */
`timescale 1ns/100ps
module uema_usb_engine_model (
    // clock
    input  wire logic           clock,
    // toward the block
    output logic [7:0]          err_event,
    output logic                host_mode,
    output uema_pkg::uema_sof_t sof_in
);
    import uema_pkg::*;
    initial begin
        err_event = 8'h00;
        host_mode = 1'b0;
        sof_in    = '0;
    end
    // one-cycle error pulse; mode decides what bit 1 stands for
    task automatic pulse(input logic [7:0] v, input logic hm);
        host_mode <= hm;
        err_event <= v;
        @(posedge clock);
        err_event <= 8'h00;
        @(posedge clock);
    endtask
    // frame number is scrambled outside the valid cycle
    task automatic sof(input logic [10:0] f);
        sof_in <= '{sof_valid: 1'b1, frame_number: f};
        @(posedge clock);
        sof_in <= '{sof_valid: 1'b0, frame_number: ~f};
        @(posedge clock);
    endtask
endmodule

/* verif/usb_error_mask_addr_frame_tb_top.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module usb_error_mask_addr_frame_tb_top;
    import uema_pkg::*;
    logic          clock = 1'b0;
    logic          rst;
    uema_apb_req_t req;
    uema_apb_rsp_t rsp;
    logic [7:0]    err_event;
    logic          host_mode;
    uema_sof_t     sof_in;
    logic [6:0]    device_address;
    logic          low_speed_token_sel;
    logic          usb_error_irq;
    logic          usb_irq_flag;
    logic [34:0]   exp_q[$];
    logic [34:0]   e;
    logic [31:0]   d;
    logic [7:0]    b;
    int            err_total = 0;
    int            n_checks = 0;
    int            seed = 32'h9b5af8a4;
    always #20 clock = ~clock;
    uema_top u_uema_top (.clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp),
        .err_event(err_event), .host_mode(host_mode), .sof_in(sof_in),
        .device_address(device_address), .low_speed_token_sel(low_speed_token_sel),
        .usb_error_irq(usb_error_irq), .usb_irq_flag(usb_irq_flag));
    uema_usb_engine_model u_uema_usb_engine_model (.clock(clock), .err_event(err_event),
        .host_mode(host_mode), .sof_in(sof_in));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
        @(posedge clock);
        req.penable <= 1'b1;
        do @(posedge clock); while (rsp.pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clock);
    endtask
    // expectation: {slave error, usb flag, error irq, read data}
    task automatic rd(input logic [7:0] a, input logic [34:0] x);
        exp_q.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask
    always @(posedge clock) begin
        if (req.psel && req.penable && !req.pwrite && rsp.pready) begin
            e = exp_q.pop_front();
            `CHK("read", e, {rsp.pslverr, usb_irq_flag, usb_error_irq, rsp.prdata})
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #(40 * 4000);
        err_total++;
        test_done;
    end
    initial begin
        req = '0;
        rst = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 8; i++) rd(8'(4 * i), {i == 7, 34'h0});
        $display("test reset done");
        apb(1'b1, UEMA_OFF_ERR_IRQ_EN, 32'hffffffff);
        rd(UEMA_OFF_ERR_IRQ_EN, {27'h0, 8'hff});
        d = $random(seed);
        apb(1'b1, UEMA_OFF_DEV_ADDR, d);
        rd(UEMA_OFF_DEV_ADDR, {27'h0, d[7:0]});
        `CHK("addr", d[7:0], {low_speed_token_sel, device_address})
        apb(1'b1, UEMA_OFF_FRAME_LOW, d);
        rd(UEMA_OFF_FRAME_LOW, 35'h0);
        $display("test registers done");
        apb(1'b1, UEMA_OFF_USB_IRQ_EN, 32'h2);
        for (int i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            apb(1'b1, UEMA_OFF_ERR_IRQ_EN, {24'h0, ~b});
            u_uema_usb_engine_model.pulse(b, 1'(i));
            rd(UEMA_OFF_ERR_STATUS, {27'h0, b});
            apb(1'b1, UEMA_OFF_ERR_IRQ_EN, {24'h0, b});
            rd(UEMA_OFF_ERR_STATUS, {3'b011, 24'h0, b});
            apb(1'b1, UEMA_OFF_USB_IRQ_EN, 32'h0);
            rd(UEMA_OFF_ERR_STATUS, {3'b001, 24'h0, b});
            apb(1'b1, UEMA_OFF_USB_IRQ_EN, 32'h2);
            apb(1'b1, UEMA_OFF_ERR_CLEAR, {24'h0, b});
            rd(UEMA_OFF_ERR_STATUS, 35'h0);
        end
        // an event landing with its own clear must survive
        fork
            apb(1'b1, UEMA_OFF_ERR_CLEAR, 32'h1);
            begin
                @(posedge clock);
                u_uema_usb_engine_model.pulse(8'h01, 1'b0);
            end
        join
        rd(UEMA_OFF_ERR_STATUS, {27'h0, 8'h01});
        apb(1'b1, UEMA_OFF_ERR_CLEAR, 32'h1);
        rd(UEMA_OFF_ERR_STATUS, 35'h0);
        $display("test masking done");
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            u_uema_usb_engine_model.sof(d[10:0]);
            rd(UEMA_OFF_FRAME_LOW, {27'h0, d[7:0]});
            rd(UEMA_OFF_FRAME_HIGH, {32'h0, d[10:8]});
        end
        $display("test frame done");
        test_done;
    end
endmodule
